// file: pmuta_pkg.sv
// Purpose: constants and types for the power-management timers and activity status block
// Assumes: 200 MHz clock, AHB-Lite register access, one word per register
// Notes:   byte address = 4 * register index
package pmuta_pkg;

    localparam int          CLK_HZ          = 200_000_000;
    // register indices; the byte address is four times the index
    localparam logic [7:0]  IDX_PIN_STATE   = 8'hCB;
    localparam logic [7:0]  IDX_DOZE_SEL    = 8'hCC;
    localparam logic [7:0]  IDX_SLEEP_SEL   = 8'hCD;
    localparam logic [7:0]  IDX_SUSP_SEL    = 8'hCE;
    localparam logic [7:0]  IDX_ACT_FLAGS   = 8'hDB;
    localparam logic [7:0]  IDX_IRQ_STATUS  = 8'hE0;
    localparam logic [7:0]  IDX_IRQ_ENABLE  = 8'hE1;
    localparam logic [7:0]  IDX_IRQ_CLEAR   = 8'hE2;
    localparam logic [7:0]  IDX_ACT_MASK    = 8'hE3;
    localparam int          ADDR_W          = 10;

    // output-state field positions
    localparam int          POS_MEM_PIN     = 7;
    localparam int          POS_SYS_PIN     = 2;
    localparam int          POS_PANEL_PIN   = 0;
    // activity flag positions
    localparam int          POS_IO_WINDOW   = 7;
    localparam int          POS_VIDEO       = 6;
    localparam int          POS_DISK        = 5;
    localparam int          POS_SERIAL      = 3;
    localparam int          POS_CARD        = 2;
    localparam int          POS_KEYBOARD    = 1;
    localparam int          POS_PIN_SELECT  = 0;
    localparam logic [7:0]  ACT_USED_MASK   = 8'hEF;
    // irq status layout: 0 doze, 1 sleep, 2 suspend expiry, 3 any unmasked activity
    localparam int          IRQ_W           = 4;
    localparam logic [7:0]  RST_ZERO8       = 8'h00;
    localparam logic [3:0]  CODE_OFF        = 4'h0;
    localparam logic [3:0]  CODE_ONE_SEC    = 4'h8;

    // timebase: one eighth-second tick drives all timers
    localparam int          EIGHTH_SEC_MS   = 125;
    localparam int          EIGHTHS_PER_MIN = 480;
    localparam int          EIGHTH_CYCLES   = CLK_HZ / 1000 * EIGHTH_SEC_MS;
    localparam int          TICK_W          = 32;
    localparam int          CNT_W           = 13;

    typedef struct packed {
        logic io_window;
        logic video;
        logic disk;
        logic serial;
        logic card;
        logic keyboard;
        logic pin_select;
    } pmuta_act_t;

    typedef struct packed {
        logic mem_supply;
        logic system_supply;
        logic panel_power;
    } pmuta_pins_t;

    typedef struct packed {
        logic doze;
        logic sleep;
        logic suspend;
    } pmuta_expiry_t;

    // eighth-second units for a doze code
    function automatic logic [CNT_W-1:0] doze_limit(input logic [3:0] code);
        if (code <= CODE_ONE_SEC)
            return CNT_W'(code);
        return CNT_W'((int'(code) - 8) * 16);
    endfunction

    // eighth-second units for a minute code
    function automatic logic [CNT_W-1:0] minute_limit(input logic [3:0] code);
        return CNT_W'(int'(code) * EIGHTHS_PER_MIN);
    endfunction

endpackage

// file: pmuta_sync.sv
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: inputs asynchronous to clock
// Notes:   output changes once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pmuta_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         resetn,
    // data
    input  wire logic [W-1:0] din,
    output var  logic [W-1:0] dout
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            dout <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_r[i] == s3_r[i])
                    dout[i] <= s3_r[i];
            end
        end
    end
endmodule
`default_nettype wire

// file: pmuta_timer.sv
// Purpose: one inactivity timer counting eighth-second ticks
// Assumes: tick is a one-cycle pulse every eighth second
// Notes:   expiry holds until activity restarts the count or a zero limit turns the timer off
`timescale 1ns/10ps
`default_nettype none
module pmuta_timer (
    // clock and reset
    input  wire logic                      clock,
    input  wire logic                      resetn,
    // control
    input  wire logic                      tick,
    input  wire logic                      restart,
    input  wire logic [pmuta_pkg::CNT_W-1:0] limit,
    // status
    output var  logic                      expired
);
    import pmuta_pkg::*;

    logic [CNT_W-1:0] count_r;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            count_r <= '0;
            expired <= 1'b0;
        end else if (restart || limit == '0) begin // [R14]
            count_r <= '0;
            expired <= 1'b0;
        end else if (tick && !expired) begin
            if (count_r + CNT_W'(1) >= limit) // [R14]
                expired <= 1'b1;
            count_r <= count_r + CNT_W'(1);
        end
    end
endmodule
`default_nettype wire

// file: pmuta_top.sv
// Purpose: power pin readback, doze/sleep/suspend timers, sticky activity flags
// Assumes: AHB-Lite slave, single word transfers, always OKAY
// Notes:   activity flags clear on read; timers count in eighth seconds
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Function
// [R1] output state bit 7 shows memory supply pin, bit 2 system supply pin, live
// [R2] output state bit 0 shows panel power pin: 0 off, 1 on
// [R3] doze code 0 off, 1..8 eighths of a second, 9..15 two-second steps
// [R4] sleep code resets to 0 meaning off, code N gives N minutes
// [R5] suspend code 0 off, code N gives N minutes
// [R6] activity flags record activity even when masked from power management
// [R7] bit 7 set by I/O window activity, cleared after read
// [R8] bit 6 set by video activity, cleared after read
// [R9] bit 5 set by disk activity, cleared after read
// [R10] bit 3 set by serial activity, cleared after read
// [R11] bit 2 set by card controller or card access, cleared after read
// [R12] bit 1 set by keyboard activity, cleared after read
// [R13] bit 0 set by chip select activity, cleared after read
// [R14] enabled timers restart on unmasked activity and signal expiry on timeout
module pmuta_top (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  resetn,
    // ahb-lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic                  hready,
    input  wire logic [31:0]           hwdata,
    output var  logic [31:0]           hrdata,
    output var  logic                  hreadyout,
    output var  logic                  hresp,
    // power pins, sensed
    input  wire pmuta_pkg::pmuta_pins_t pins_in,
    // activity pulses from peripherals
    input  wire pmuta_pkg::pmuta_act_t  activity,
    // timer expiry to the power state logic
    output var  pmuta_pkg::pmuta_expiry_t expiry,
    // interrupt
    output var  logic                  irq
);
    import pmuta_pkg::*;

    pmuta_pins_t  pins_s;
    pmuta_act_t   act_r;
    logic [7:0]   act_mask_r;
    logic [3:0]   doze_timeout_code_r;
    logic [3:0]   sleep_timeout_code_r;
    logic [3:0]   suspend_timeout_code_r;
    logic [IRQ_W-1:0] irq_status_r;
    logic [IRQ_W-1:0] irq_enable_r;
    logic [TICK_W-1:0] tick_cnt_r;
    logic         tick_r;
    logic         activity_seen_r;
    logic         doze_exp;
    logic         sleep_exp;
    logic         susp_exp;
    logic         ph_valid_r;
    logic         ph_write_r;
    logic [7:0]   ph_idx_r;
    logic         rd_act;
    logic [7:0]   act_vec;
    logic [7:0]   act_flags_v;
    logic [7:0]   act_unmasked;
    logic [IRQ_W-1:0] irq_events;
    logic [IRQ_W-1:0] irq_clear;
    logic [31:0]  rdata_nxt;
    logic         addr_ok;
    pmuta_expiry_t exp_prev_r;

    // pins come from pads, so they are synchronised
    pmuta_sync #(.W(3)) u_pin_sync (
        .clock  (clock),
        .resetn (resetn),
        .din    (pins_in),
        .dout   (pins_s)
    );

    // address phase capture; word aligned, decoded by index
    assign addr_ok = (haddr[31:ADDR_W] == '0) && (haddr[1:0] == 2'b00);

    always_ff @(posedge clock) begin
        if (!resetn) begin
            ph_valid_r <= 1'b0;
            ph_write_r <= 1'b0;
            ph_idx_r   <= RST_ZERO8;
        end else if (hready) begin
            ph_valid_r <= hsel && htrans[1] && addr_ok;
            ph_write_r <= hwrite;
            ph_idx_r   <= haddr[9:2];
        end
    end

    // zero wait states; unmapped indices read zero, reads outside the window or misaligned keep the last data, writes are dropped
    always_ff @(posedge clock) begin
        if (!resetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // read data is built in the address phase so it stands with the data phase
    always_comb begin
        rdata_nxt = '0;
        unique case (haddr[9:2])
            IDX_PIN_STATE: begin
                rdata_nxt[POS_MEM_PIN]   = pins_s.mem_supply;    // [R1]
                rdata_nxt[POS_SYS_PIN]   = pins_s.system_supply; // [R1]
                rdata_nxt[POS_PANEL_PIN] = pins_s.panel_power;   // [R2]
            end
            IDX_DOZE_SEL:   rdata_nxt[3:0] = doze_timeout_code_r;
            IDX_SLEEP_SEL:  rdata_nxt[3:0] = sleep_timeout_code_r;
            IDX_SUSP_SEL:   rdata_nxt[3:0] = suspend_timeout_code_r;
            IDX_ACT_FLAGS:  rdata_nxt[7:0] = act_flags_v;
            IDX_IRQ_STATUS: rdata_nxt[IRQ_W-1:0] = irq_status_r;
            IDX_IRQ_ENABLE: rdata_nxt[IRQ_W-1:0] = irq_enable_r;
            IDX_ACT_MASK:   rdata_nxt[7:0] = act_mask_r;
            default:        rdata_nxt = '0;
        endcase
    end

    assign rd_act = hready && hsel && htrans[1] && !hwrite && addr_ok
                    && haddr[9:2] == IDX_ACT_FLAGS;

    always_ff @(posedge clock) begin
        if (!resetn)
            hrdata <= '0;
        else if (hready && hsel && htrans[1] && !hwrite && addr_ok)
            hrdata <= rdata_nxt;
    end

    // writable registers
    always_ff @(posedge clock) begin
        if (!resetn) begin
            doze_timeout_code_r    <= CODE_OFF;
            sleep_timeout_code_r   <= CODE_OFF; // [R4]
            suspend_timeout_code_r <= CODE_OFF;
            irq_enable_r           <= '0;
            act_mask_r             <= RST_ZERO8;
        end else if (ph_valid_r && ph_write_r) begin
            unique case (ph_idx_r)
                IDX_DOZE_SEL:   doze_timeout_code_r    <= hwdata[3:0];
                IDX_SLEEP_SEL:  sleep_timeout_code_r   <= hwdata[3:0];
                IDX_SUSP_SEL:   suspend_timeout_code_r <= hwdata[3:0];
                IDX_IRQ_ENABLE: irq_enable_r           <= hwdata[IRQ_W-1:0];
                IDX_ACT_MASK:   act_mask_r             <= hwdata[7:0] & ACT_USED_MASK;
                default: ;
            endcase
        end
    end

    // activity flags: set ignores the mask, set wins over read clear
    assign act_vec = {activity.io_window, activity.video, activity.disk, 1'b0,
                      activity.serial, activity.card, activity.keyboard,
                      activity.pin_select};
    assign act_flags_v = {act_r.io_window, act_r.video, act_r.disk, 1'b0,
                          act_r.serial, act_r.card, act_r.keyboard, act_r.pin_select};

    always_ff @(posedge clock) begin
        if (!resetn) begin
            act_r <= '0;
        end else begin
            act_r.io_window  <= act_vec[POS_IO_WINDOW] | (act_r.io_window & !rd_act); // [R6] [R7]
            act_r.video      <= act_vec[POS_VIDEO] | (act_r.video & !rd_act);         // [R8]
            act_r.disk       <= act_vec[POS_DISK] | (act_r.disk & !rd_act);           // [R9]
            act_r.serial     <= act_vec[POS_SERIAL] | (act_r.serial & !rd_act);       // [R10]
            act_r.card       <= act_vec[POS_CARD] | (act_r.card & !rd_act);           // [R11]
            act_r.keyboard   <= act_vec[POS_KEYBOARD] | (act_r.keyboard & !rd_act);   // [R12]
            act_r.pin_select <= act_vec[POS_PIN_SELECT] | (act_r.pin_select & !rd_act); // [R13]
        end
    end

    // mask bit set keeps that source from restarting the timers
    assign act_unmasked = act_vec & ~act_mask_r;

    always_ff @(posedge clock) begin
        if (!resetn)
            activity_seen_r <= 1'b0;
        else
            activity_seen_r <= |act_unmasked; // [R14]
    end

    // eighth-second timebase shared by all three timers
    always_ff @(posedge clock) begin
        if (!resetn) begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b0;
        end else if (tick_cnt_r == TICK_W'(EIGHTH_CYCLES - 1)) begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + TICK_W'(1);
            tick_r     <= 1'b0;
        end
    end

    pmuta_timer u_doze (
        .clock   (clock),
        .resetn  (resetn),
        .tick    (tick_r),
        .restart (activity_seen_r),
        .limit   (doze_limit(doze_timeout_code_r)), // [R3]
        .expired (doze_exp)
    );

    pmuta_timer u_sleep (
        .clock   (clock),
        .resetn  (resetn),
        .tick    (tick_r),
        .restart (activity_seen_r),
        .limit   (minute_limit(sleep_timeout_code_r)), // [R4]
        .expired (sleep_exp)
    );

    pmuta_timer u_susp (
        .clock   (clock),
        .resetn  (resetn),
        .tick    (tick_r),
        .restart (activity_seen_r),
        .limit   (minute_limit(suspend_timeout_code_r)), // [R5]
        .expired (susp_exp)
    );

    always_ff @(posedge clock) begin
        if (!resetn) begin
            expiry     <= '0;
            exp_prev_r <= '0;
        end else begin
            expiry     <= '{doze: doze_exp, sleep: sleep_exp, suspend: susp_exp}; // [R14]
            exp_prev_r <= expiry;
        end
    end

    // interrupt events: rising expiry edges and any unmasked activity
    assign irq_events = {activity_seen_r,
                         expiry.suspend & !exp_prev_r.suspend,
                         expiry.sleep & !exp_prev_r.sleep,
                         expiry.doze & !exp_prev_r.doze};
    assign irq_clear  = (ph_valid_r && ph_write_r && ph_idx_r == IDX_IRQ_CLEAR)
                        ? hwdata[IRQ_W-1:0] : '0;

    always_ff @(posedge clock) begin
        if (!resetn)
            irq_status_r <= '0;
        else
            irq_status_r <= irq_events | (irq_status_r & ~irq_clear);
    end

    always_ff @(posedge clock) begin
        if (!resetn)
            irq <= 1'b0;
        else
            irq <= |(irq_status_r & irq_enable_r);
    end
endmodule
`default_nettype wire

// file: pmuta_top_asserts.sv
// Purpose: port checks for pmuta_top
// Assumes: byte address = 4 * register index
// Notes:   real expiry needs seconds, so only its quiet side is watched
`timescale 1ns/10ps
`default_nettype none
module pmuta_top_asserts
    import pmuta_pkg::*;
(
    // clock and reset
    input  wire logic                     clock,
    input  wire logic                     resetn,
    // ahb-lite
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic                     hready,
    input  wire logic [31:0]              hwdata,
    input  wire logic [31:0]              hrdata,
    input  wire logic                     hreadyout,
    input  wire logic                     hresp,
    // pins, activity, expiry
    input  wire pmuta_pkg::pmuta_pins_t   pins_in,
    input  wire pmuta_pkg::pmuta_act_t    activity,
    input  wire pmuta_pkg::pmuta_expiry_t expiry,
    input  wire logic                     irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    logic       take;
    logic       rd_act;
    logic       rd_pin;
    logic [7:0] act_bits;
    logic [7:0] pin_bits;
    function automatic logic at(input logic [31:0] a, input logic [7:0] idx);
        return a[9:0] == {idx, 2'b00};
    endfunction
    assign take     = hsel && hready && htrans[1] && haddr[31:10] == 22'h0;
    assign rd_act   = take && !hwrite && at(haddr, IDX_ACT_FLAGS);
    assign rd_pin   = take && !hwrite && at(haddr, IDX_PIN_STATE);
    assign act_bits = {activity[6:4], 1'b0, activity[3:0]};
    assign pin_bits = {pins_in.mem_supply, 4'h0, pins_in.system_supply, 1'b0, pins_in.panel_power};

    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and okay");
    a_reserved_zero: assert property (take && !hwrite |=> hrdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    a_pin_readback: assert property ($stable(pins_in)[*7] ##0 rd_pin |=>
        hrdata[7:0] == $past(pin_bits))
        else $error("pin state readback wrong");
    a_flag_sets: assert property (act_bits != 8'h00 ##1 !rd_act ##1 rd_act |=>
        (hrdata[7:0] & $past(act_bits, 3)) == $past(act_bits, 3))
        else $error("activity flag not recorded");
    // single transfers take two cycles, so the second read follows two cycles on
    a_flag_clears: assert property ((act_bits == 8'h00)[*2] ##0 rd_act ##1
        act_bits == 8'h00 ##1 (rd_act && act_bits == 8'h00) |=> hrdata[7:0] == 8'h00)
        else $error("activity flags not cleared by read");
    a_reset_quiet: assert property ($rose(resetn) |-> expiry == '0 && !irq)
        else $error("expiry or irq after reset");
    a_doze_off: assert property (take && hwrite && at(haddr, IDX_DOZE_SEL) ##1
        hwdata[3:0] == 4'h0 |-> ##[1:3] !expiry.doze)
        else $error("doze expiry with code zero");
    a_sleep_off: assert property (take && hwrite && at(haddr, IDX_SLEEP_SEL) ##1
        hwdata[3:0] == 4'h0 |-> ##[1:3] !expiry.sleep)
        else $error("sleep expiry with code zero");
    a_susp_off: assert property (take && hwrite && at(haddr, IDX_SUSP_SEL) ##1
        hwdata[3:0] == 4'h0 |-> ##[1:3] !expiry.suspend)
        else $error("suspend expiry with code zero");

    c_flag_read: cover property (rd_act ##1 hrdata[7:0] != 8'h00);
    c_pin_read: cover property (rd_pin);
    c_irq_high: cover property (irq);
endmodule
bind pmuta_top pmuta_top_asserts pmuta_top_asserts_i (.clock(clock), .resetn(resetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pins_in(pins_in), .activity(activity), .expiry(expiry), .irq(irq));
`default_nettype wire

// file: pmuta_switch_model.sv
// Purpose: external supply switches feeding back their pin levels
// Assumes: a switch settles a few cycles after it is commanded
// Notes:   pins are levels and always driven
`timescale 1ns/10ps
`default_nettype none
module pmuta_switch_model
    import pmuta_pkg::*;
#(
    parameter int SETTLE = 3
) (
    // clock
    input  wire logic                   clock,
    // command and sensed level
    input  wire pmuta_pkg::pmuta_pins_t command,
    output var  pmuta_pkg::pmuta_pins_t level
);
    pmuta_pins_t pipe_r [SETTLE];
    always_ff @(posedge clock) begin
        pipe_r[0] <= command;
        for (int i = 1; i < SETTLE; i++) begin
            pipe_r[i] <= pipe_r[i-1];
        end
    end
    assign level = pipe_r[SETTLE-1];
endmodule
`default_nettype wire

// file: pmuta_top_tb.sv
// Purpose: self-checking bench for pmuta_top
// Assumes: 200 MHz clock, ahb-lite master tasks below
// Notes:   timer expiry takes seconds, so codes are checked by readback
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module pmuta_top_tb;
    import pmuta_pkg::*;
    localparam int LIMIT = 6000;
    logic          clock;
    logic          resetn   = 1'b0;
    logic          hsel     = 1'b0;
    logic [31:0]   haddr    = 32'h0000_0000;
    logic [1:0]    htrans   = 2'b00;
    logic          hwrite   = 1'b0;
    logic [2:0]    hsize    = 3'b010;
    logic [31:0]   hwdata   = 32'h0000_0000;
    logic [31:0]   hrdata;
    logic          hreadyout;
    logic          hresp;
    pmuta_pins_t   pin_cmd  = 3'b000;
    pmuta_pins_t   pins_in;
    pmuta_act_t    activity = 7'h00;
    pmuta_expiry_t expiry;
    logic          irq;
    logic [31:0]   rd;
    int            n_errors = 0;
    int            comparisons = 0;
    int            cycles = 0;

    pmuta_top pmuta_top_i (.clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pins_in(pins_in), .activity(activity), .expiry(expiry), .irq(irq));
    pmuta_switch_model pmuta_switch_model_i (.clock(clock), .command(pin_cmd), .level(pins_in));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // a hung handshake would otherwise stall the run for ever
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_errors++;
            end_of_test();
        end
    end

    function automatic logic [31:0] ba(input logic [7:0] idx);
        return {22'h0, idx, 2'b00};
    endfunction
    function automatic logic [31:0] fb(input logic [6:0] v);
        return {24'h0, v[6:4], 1'b0, v[3:0]};
    endfunction

    // single transfer; entered just after a rising edge
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        xfer(1'b1, ba(i), d);
    endtask
    task automatic rdr(input logic [7:0] i);
        xfer(1'b0, ba(i), 32'h0000_0000);
    endtask
    task automatic pulse(input logic [6:0] v);
        activity <= v;
        @(posedge clock);
        activity <= 7'h00;
        repeat (4) @(posedge clock);
    endtask

    task automatic t_reset();
        logic [7:0] idx [4] = '{IDX_DOZE_SEL, IDX_SLEEP_SEL, IDX_SUSP_SEL, IDX_ACT_FLAGS};
        `CHK("expiry", 3'b000, expiry)
        `CHK("irq", 1'b0, irq)
        for (int k = 0; k < 4; k++) begin
            rdr(idx[k]);
            `CHK("reset value", 32'h0000_0000, rd)
        end
        $display("t_reset done");
    endtask

    task automatic t_codes();
        logic [7:0] idx [3] = '{IDX_DOZE_SEL, IDX_SLEEP_SEL, IDX_SUSP_SEL};
        for (int k = 0; k < 3; k++) begin
            for (int c = 15; c >= 0; c--) begin
                wr(idx[k], {28'hFFFF_FFF, 4'(c)});
                rdr(idx[k]);
                `CHK("timer code", {28'h0, 4'(c)}, rd)
            end
        end
        `CHK("expiry off", 3'b000, expiry)
        $display("t_codes done");
    endtask

    task automatic t_pins();
        for (int p = 0; p < 8; p++) begin
            pin_cmd <= 3'(p);
            repeat (12) @(posedge clock);
            rdr(IDX_PIN_STATE);
            `CHK("pin state", {24'h0, p[2], 4'h0, p[1], 1'b0, p[0]}, rd)
        end
        wr(IDX_PIN_STATE, 32'h0000_0000);
        rdr(IDX_PIN_STATE);
        `CHK("pin state ro", 32'h0000_0085, rd)
        $display("t_pins done");
    endtask

    // second pass masks every source: the flags must still record it
    task automatic t_flags();
        logic [7:0] m [2] = '{8'h00, 8'hEF};
        for (int k = 0; k < 2; k++) begin
            wr(IDX_ACT_MASK, {24'h0, m[k]});
            for (int b = 0; b < 7; b++) begin
                pulse(7'(1 << b));
                rdr(IDX_ACT_FLAGS);
                `CHK("flag set", fb(7'(1 << b)), rd)
                rdr(IDX_ACT_FLAGS);
                `CHK("flag cleared", 32'h0000_0000, rd)
            end
        end
        wr(IDX_ACT_MASK, 32'h0000_0000);
        $display("t_flags done");
    endtask

    // four reads in a row; video arrives in the first read's address cycle, set wins
    task automatic t_b2b();
        logic [31:0] e [4] = '{32'h0000_0002, 32'h0000_0040, 32'h0000_0000, 32'h0000_0000};
        pulse(7'h02);
        activity <= 7'h20;
        for (int k = 0; k < 4; k++) begin
            rdr(IDX_ACT_FLAGS);
            activity <= 7'h00;
            `CHK("pipelined flags", e[k], rd)
        end
        $display("t_b2b done");
    endtask

    task automatic t_irq();
        wr(IDX_IRQ_CLEAR, 32'h0000_000F);
        wr(IDX_IRQ_ENABLE, 32'h0000_0008);
        `CHK("irq idle", 1'b0, irq)
        pulse(7'h01);
        `CHK("irq raised", 1'b1, irq)
        rdr(IDX_IRQ_STATUS);
        `CHK("irq status", 1'b1, rd[3])
        wr(IDX_IRQ_CLEAR, 32'h0000_0008);
        // irq is registered from the status, so it falls one edge after the clear
        repeat (2) @(posedge clock);
        `CHK("irq cleared", 1'b0, irq)
        rdr(IDX_IRQ_CLEAR);
        `CHK("clear reads zero", 32'h0000_0000, rd)
        wr(IDX_ACT_MASK, 32'h0000_00EF);
        pulse(7'h02);
        `CHK("masked irq", 1'b0, irq)
        rdr(IDX_ACT_FLAGS);
        // chip select flag from the unmasked pulse above is still unread
        `CHK("masked flag", 32'h0000_0003, rd)
        wr(8'hFC, 32'hFFFF_FFFF);
        rdr(8'hFC);
        `CHK("unmapped", 32'h0000_0000, rd)
        $display("t_irq done");
    endtask

    initial begin
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        t_reset();
        t_codes();
        t_pins();
        t_flags();
        t_b2b();
        t_irq();
        end_of_test();
    end
endmodule
`default_nettype wire
